/* logic/activity_counter_enable_pkg.sv */
`default_nettype none
package activity_counter_enable_pkg;
   // Counter group sizes and view width
   localparam int ARCH_COUNT = 4;
   localparam int AUX_COUNT = 3;
   localparam int DATA_W = 32;
   localparam int DBG_ADDR_W = 12;
   // System-register encoding: op0, op1 and CRn shared by all four views, CRm per counter group, op2 per view
   localparam logic [1:0] SR_OP0 = 2'h3;
   localparam logic [2:0] SR_OP1 = 3'h3;
   localparam logic [3:0] SR_CRN = 4'hF;
   localparam logic [3:0] SR_CRM_ARCH = 4'h2;
   localparam logic [3:0] SR_CRM_AUX = 4'h3;
   localparam logic [2:0] SR_OP2_ARCH_CLR = 3'h4;
   localparam logic [2:0] SR_OP2_ARCH_SET = 3'h5;
   localparam logic [2:0] SR_OP2_AUX_CLR = 3'h0;
   localparam logic [2:0] SR_OP2_AUX_SET = 3'h1;
   // External debug offsets, read-only
   localparam logic [11:0] DBG_ARCH_SET_OFS = 12'hC00;
   localparam logic [11:0] DBG_AUX_SET_OFS = 12'hC04;
   localparam logic [11:0] DBG_ARCH_CLR_OFS = 12'hC20;
   localparam logic [11:0] DBG_AUX_CLR_OFS = 12'hC24;
   // Trap control bit in both auxiliary control registers
   localparam int TRAP_BIT_POS = 30;
   // Exception levels
   localparam logic [1:0] EL0 = 2'h0;
   localparam logic [1:0] EL1 = 2'h1;
   localparam logic [1:0] EL2 = 2'h2;
   localparam logic [1:0] EL3 = 2'h3;
   // Reset values
   localparam logic [3:0] ARCH_ENABLE_RESET = 4'h0;
   localparam logic [2:0] AUX_ENABLE_RESET = 3'h0;
endpackage
`default_nettype wire

/* logic/activity_counter_enable_regs.sv */
`default_nettype none
module activity_counter_enable_regs
   import activity_counter_enable_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic sysreg_req_i,
   input wire logic sysreg_write_i,
   input wire logic [1:0] sysreg_op0_i,
   input wire logic [2:0] sysreg_op1_i,
   input wire logic [3:0] sysreg_crn_i,
   input wire logic [3:0] sysreg_crm_i,
   input wire logic [2:0] sysreg_op2_i,
   input wire logic [DATA_W-1:0] sysreg_wdata_i,
   input wire logic [1:0] sysreg_el_i,
   input wire logic sysreg_nonsecure_i,
   input wire logic [DATA_W-1:0] level3_aux_control_i,
   input wire logic [DATA_W-1:0] level2_aux_control_i,
   output logic sysreg_ack_o,
   output logic [DATA_W-1:0] sysreg_rdata_o,
   output logic sysreg_trap_o,
   output logic [1:0] sysreg_trap_el_o,
   input wire logic dbg_req_i,
   input wire logic dbg_write_i,
   input wire logic [DBG_ADDR_W-1:0] dbg_addr_i,
   output logic dbg_ack_o,
   output logic dbg_err_o,
   output logic [DATA_W-1:0] dbg_rdata_o,
   output logic [ARCH_COUNT-1:0] arch_count_enable_o,
   output logic [AUX_COUNT-1:0] aux_count_enable_o
);

   // Enable state
   logic [ARCH_COUNT-1:0] arch_en_r;
   logic [ARCH_COUNT-1:0] arch_en_nxt;
   logic [AUX_COUNT-1:0] aux_en_r;
   logic [AUX_COUNT-1:0] aux_en_nxt;

   // System-register answer state
   logic sr_ack_r;
   logic sr_ack_nxt;
   logic [DATA_W-1:0] sr_rdata_r;
   logic [DATA_W-1:0] sr_rdata_nxt;
   logic sr_trap_r;
   logic sr_trap_nxt;
   logic [1:0] sr_trap_el_r;
   logic [1:0] sr_trap_el_nxt;

   // Debug answer state
   logic dbg_ack_r;
   logic dbg_ack_nxt;
   logic dbg_err_r;
   logic dbg_err_nxt;
   logic [DATA_W-1:0] dbg_rdata_r;
   logic [DATA_W-1:0] dbg_rdata_nxt;

   // Decode
   logic sr_space;
   logic sel_arch_clr;
   logic sel_arch_set;
   logic sel_aux_clr;
   logic sel_aux_set;
   logic sr_hit;
   logic trap_to_el3;
   logic trap_to_el2;
   logic sr_trapped;
   logic sr_do_write;
   logic [ARCH_COUNT-1:0] arch_set_mask;
   logic [ARCH_COUNT-1:0] arch_clr_mask;
   logic [AUX_COUNT-1:0] aux_set_mask;
   logic [AUX_COUNT-1:0] aux_clr_mask;
   logic [DATA_W-1:0] arch_view;
   logic [DATA_W-1:0] aux_view;

   always_comb begin
      sr_space = sysreg_req_i && (sysreg_op0_i == SR_OP0) && (sysreg_op1_i == SR_OP1)
                 && (sysreg_crn_i == SR_CRN);
      sel_arch_clr = sr_space && (sysreg_crm_i == SR_CRM_ARCH)
                     && (sysreg_op2_i == SR_OP2_ARCH_CLR);
      sel_arch_set = sr_space && (sysreg_crm_i == SR_CRM_ARCH)
                     && (sysreg_op2_i == SR_OP2_ARCH_SET);
      sel_aux_clr = sr_space && (sysreg_crm_i == SR_CRM_AUX)
                    && (sysreg_op2_i == SR_OP2_AUX_CLR);
      sel_aux_set = sr_space && (sysreg_crm_i == SR_CRM_AUX)
                    && (sysreg_op2_i == SR_OP2_AUX_SET);
      // Every level may reach the views unless a trap intervenes
      sr_hit = sel_arch_clr || sel_arch_set || sel_aux_clr || sel_aux_set;
      trap_to_el3 = level3_aux_control_i[TRAP_BIT_POS] && (sysreg_el_i != EL3);
      trap_to_el2 = !trap_to_el3 && level2_aux_control_i[TRAP_BIT_POS]
                    && sysreg_nonsecure_i
                    && ((sysreg_el_i == EL0) || (sysreg_el_i == EL1));
      sr_trapped = trap_to_el3 || trap_to_el2;
      sr_do_write = sr_hit && sysreg_write_i && !sr_trapped;
      // Only the implemented low bits of the write data are used
      arch_set_mask = (sr_do_write && sel_arch_set) ?
                      sysreg_wdata_i[ARCH_COUNT-1:0] : '0;
      arch_clr_mask = (sr_do_write && sel_arch_clr) ?
                      sysreg_wdata_i[ARCH_COUNT-1:0] : '0;
      aux_set_mask = (sr_do_write && sel_aux_set) ?
                     sysreg_wdata_i[AUX_COUNT-1:0] : '0;
      aux_clr_mask = (sr_do_write && sel_aux_clr) ?
                     sysreg_wdata_i[AUX_COUNT-1:0] : '0;
      arch_view = {{(DATA_W-ARCH_COUNT){1'b0}}, arch_en_r};
      aux_view = {{(DATA_W-AUX_COUNT){1'b0}}, aux_en_r};
   end

   // One flop per counter, steered by both views
   genvar gi;
   generate
      for (gi = 0; gi < ARCH_COUNT; gi++) begin : g_arch
         always_comb begin
            arch_en_nxt[gi] = arch_set_mask[gi]
                              || (arch_en_r[gi] && !arch_clr_mask[gi]);
         end
      end
      for (gi = 0; gi < AUX_COUNT; gi++) begin : g_aux
         always_comb begin
            aux_en_nxt[gi] = aux_set_mask[gi]
                             || (aux_en_r[gi] && !aux_clr_mask[gi]);
         end
      end
   endgenerate

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         arch_en_r <= ARCH_ENABLE_RESET;
         aux_en_r <= AUX_ENABLE_RESET;
      end else begin
         arch_en_r <= arch_en_nxt;
         aux_en_r <= aux_en_nxt;
      end
   end

   // System-register answer, one cycle after the request
   always_comb begin
      sr_ack_nxt = sr_hit;
      sr_trap_nxt = sr_hit && sr_trapped;
      sr_trap_el_nxt = EL0;
      if (sr_hit && trap_to_el3) begin
         sr_trap_el_nxt = EL3;
      end else if (sr_hit && trap_to_el2) begin
         sr_trap_el_nxt = EL2;
      end
      sr_rdata_nxt = '0;
      if (sr_hit && !sysreg_write_i && !sr_trapped) begin
         if (sel_arch_clr || sel_arch_set) begin
            sr_rdata_nxt = arch_view;
         end else begin
            sr_rdata_nxt = aux_view;
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sr_ack_r <= 1'b0;
         sr_rdata_r <= '0;
         sr_trap_r <= 1'b0;
         sr_trap_el_r <= EL0;
      end else begin
         sr_ack_r <= sr_ack_nxt;
         sr_rdata_r <= sr_rdata_nxt;
         sr_trap_r <= sr_trap_nxt;
         sr_trap_el_r <= sr_trap_el_nxt;
      end
   end

   // Debug port: read-only views, writes and unmapped offsets flag an error
   always_comb begin
      dbg_ack_nxt = dbg_req_i;
      dbg_err_nxt = 1'b0;
      dbg_rdata_nxt = '0;
      if (dbg_req_i) begin
         if (dbg_write_i) begin
            dbg_err_nxt = 1'b1;
         end else begin
            case (dbg_addr_i)
               DBG_ARCH_SET_OFS: dbg_rdata_nxt = arch_view;
               DBG_AUX_SET_OFS: dbg_rdata_nxt = aux_view;
               DBG_ARCH_CLR_OFS: dbg_rdata_nxt = arch_view;
               DBG_AUX_CLR_OFS: dbg_rdata_nxt = aux_view;
               default: dbg_err_nxt = 1'b1;
            endcase
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         dbg_ack_r <= 1'b0;
         dbg_err_r <= 1'b0;
         dbg_rdata_r <= '0;
      end else begin
         dbg_ack_r <= dbg_ack_nxt;
         dbg_err_r <= dbg_err_nxt;
         dbg_rdata_r <= dbg_rdata_nxt;
      end
   end

   assign sysreg_ack_o = sr_ack_r;
   assign sysreg_rdata_o = sr_rdata_r;
   assign sysreg_trap_o = sr_trap_r;
   assign sysreg_trap_el_o = sr_trap_el_r;
   assign dbg_ack_o = dbg_ack_r;
   assign dbg_err_o = dbg_err_r;
   assign dbg_rdata_o = dbg_rdata_r;
   assign arch_count_enable_o = arch_en_r;
   assign aux_count_enable_o = aux_en_r;

   // Checks
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (rst_i);

   AST_ARCH_CLR_READ: assert property (
      (sel_arch_clr && !sysreg_write_i && !sr_trapped)
      |=> (sysreg_ack_o && (sysreg_rdata_o[3:0] == $past(arch_count_enable_o))))
      else $error("Architected clear view read mismatch");

   AST_ARCH_CLR_WRITE: assert property (
      (sel_arch_clr && sysreg_write_i && !sr_trapped)
      |=> (arch_count_enable_o
           == ($past(arch_count_enable_o) & ~$past(sysreg_wdata_i[3:0]))))
      else $error("Architected clear write wrong");

   AST_AUX_CLR_WRITE: assert property (
      (sel_aux_clr && sysreg_write_i && !sr_trapped)
      |=> (aux_count_enable_o
           == ($past(aux_count_enable_o) & ~$past(sysreg_wdata_i[2:0]))))
      else $error("Auxiliary clear write wrong");

   AST_ARCH_SET_WRITE: assert property (
      (sel_arch_set && sysreg_write_i && !sr_trapped)
      |=> (arch_count_enable_o
           == ($past(arch_count_enable_o) | $past(sysreg_wdata_i[3:0]))))
      else $error("Architected set write wrong");

   AST_AUX_SET_WRITE: assert property (
      (sel_aux_set && sysreg_write_i && !sr_trapped)
      |=> (aux_count_enable_o
           == ($past(aux_count_enable_o) | $past(sysreg_wdata_i[2:0]))))
      else $error("Auxiliary set write wrong");

   AST_ARCH_UPPER_ZERO: assert property (
      ((sel_arch_set || sel_arch_clr) && !sysreg_write_i)
      |=> (sysreg_rdata_o[31:4] == 28'h0000000))
      else $error("Architected view upper bits not zero");

   AST_AUX_READ: assert property (
      ((sel_aux_set || sel_aux_clr) && !sysreg_write_i && !sr_trapped)
      |=> ((sysreg_rdata_o[31:3] == 29'h00000000)
           && (sysreg_rdata_o[2:0] == $past(aux_count_enable_o))))
      else $error("Auxiliary view read wrong");

   AST_DECODE_ACK: assert property (
      (sysreg_req_i && (sysreg_op0_i == 2'h3) && (sysreg_op1_i == 3'h3)
       && (sysreg_crn_i == 4'hF) && (sysreg_crm_i == 4'h3) && (sysreg_op2_i == 3'h1))
      |=> sysreg_ack_o)
      else $error("Auxiliary set encoding not answered");

   AST_DBG_CLR: assert property (
      (dbg_req_i && !dbg_write_i && (dbg_addr_i == 12'hC20))
      |=> (dbg_ack_o && !dbg_err_o
           && (dbg_rdata_o == {28'h0000000, $past(arch_count_enable_o)})))
      else $error("Debug clear view read wrong");

   AST_DBG_SET: assert property (
      (dbg_req_i && !dbg_write_i && (dbg_addr_i == 12'hC04))
      |=> (dbg_ack_o && !dbg_err_o
           && (dbg_rdata_o == {29'h00000000, $past(aux_count_enable_o)})))
      else $error("Debug set view read wrong");

   AST_DBG_NO_WRITE: assert property (
      (dbg_req_i && dbg_write_i && !sr_do_write)
      |=> (dbg_err_o && $stable(arch_count_enable_o) && $stable(aux_count_enable_o)))
      else $error("Debug write was not refused");

   AST_EL0_ACCESS: assert property (
      (sr_hit && (sysreg_el_i == EL0) && !level3_aux_control_i[30]
       && !level2_aux_control_i[30])
      |=> (sysreg_ack_o && !sysreg_trap_o))
      else $error("Level 0 access refused");

   AST_TRAP_EL3: assert property (
      (sr_hit && level3_aux_control_i[30] && (sysreg_el_i != EL3))
      |=> (sysreg_trap_o && (sysreg_trap_el_o == 2'h3)
           && $stable(arch_count_enable_o) && (sysreg_rdata_o == 32'h00000000)))
      else $error("Level 3 trap missing");

   AST_TRAP_EL2: assert property (
      (sr_hit && !level3_aux_control_i[30] && level2_aux_control_i[30]
       && sysreg_nonsecure_i && (sysreg_el_i <= EL1))
      |=> (sysreg_trap_o && (sysreg_trap_el_o == 2'h2) && $stable(aux_count_enable_o)))
      else $error("Level 2 trap missing");

   AST_SHARED_FLOP: assert property (
      (sel_arch_set && sysreg_write_i && !sr_trapped)
      ##1 (sel_arch_clr && !sysreg_write_i && !sr_trapped)
      |=> (sysreg_rdata_o[3:0] == ($past(sysreg_wdata_i[3:0], 2) | $past(arch_count_enable_o, 2))))
      else $error("Set not visible through clear view");

endmodule
`default_nettype wire

/* verif/core_access_model.sv */
`default_nettype none
module core_access_model
   import activity_counter_enable_pkg::*;
(
   input wire logic clk_i,
   output logic req_o,
   output logic wr_o,
   output logic [1:0] op0_o,
   output logic [2:0] op1_o,
   output logic [3:0] crn_o,
   output logic [3:0] crm_o,
   output logic [2:0] op2_o,
   output logic [DATA_W-1:0] wdata_o,
   output logic [1:0] el_o,
   output logic ns_o,
   output logic dreq_o,
   output logic dwr_o,
   output logic [DBG_ADDR_W-1:0] daddr_o,
   input wire logic ack_i,
   input wire logic [DATA_W-1:0] rdata_i,
   input wire logic trap_i,
   input wire logic [1:0] trap_el_i,
   input wire logic dack_i,
   input wire logic derr_i,
   input wire logic [DATA_W-1:0] drdata_i
);
   timeunit 1ns;
   timeprecision 1ns;
   assign op0_o = SR_OP0;
   assign op1_o = SR_OP1;
   assign crn_o = SR_CRN;
   initial begin
      req_o = 1'h0;
      wr_o = 1'h0;
      crm_o = 4'h0;
      op2_o = 3'h0;
      wdata_o = 32'h0;
      el_o = 2'h0;
      ns_o = 1'h0;
      dreq_o = 1'h0;
      dwr_o = 1'h0;
      daddr_o = 12'h0;
   end
   // One-cycle request pulse, answer sampled one cycle later
   task automatic sr(input logic w, input logic [3:0] m, input logic [2:0] p,
      input logic [DATA_W-1:0] d, input logic [1:0] l, input logic s, output logic a,
      output logic [DATA_W-1:0] r, output logic t, output logic [1:0] te);
      @(negedge clk_i);
      req_o = 1'h1;
      wr_o = w;
      crm_o = m;
      op2_o = p;
      wdata_o = d;
      el_o = l;
      ns_o = s;
      @(negedge clk_i);
      a = ack_i;
      r = rdata_i;
      t = trap_i;
      te = trap_el_i;
      req_o = 1'h0;
      // Released lines stop showing the last value
      wdata_o = ~wdata_o;
      crm_o = ~crm_o;
      op2_o = ~op2_o;
   endtask
   // Set write then clear read on the next cycle, request held high between them
   task automatic sr_pair(input logic [DATA_W-1:0] d, output logic a,
      output logic [DATA_W-1:0] r);
      @(negedge clk_i);
      req_o = 1'h1;
      wr_o = 1'h1;
      crm_o = SR_CRM_ARCH;
      op2_o = SR_OP2_ARCH_SET;
      wdata_o = d;
      el_o = EL0;
      ns_o = 1'h0;
      @(negedge clk_i);
      wr_o = 1'h0;
      op2_o = SR_OP2_ARCH_CLR;
      @(negedge clk_i);
      a = ack_i;
      r = rdata_i;
      req_o = 1'h0;
      wdata_o = ~wdata_o;
      crm_o = ~crm_o;
      op2_o = ~op2_o;
   endtask
   task automatic dr(input logic w, input logic [DBG_ADDR_W-1:0] ad, output logic a,
      output logic e, output logic [DATA_W-1:0] r);
      @(negedge clk_i);
      dreq_o = 1'h1;
      dwr_o = w;
      daddr_o = ad;
      @(negedge clk_i);
      a = dack_i;
      e = derr_i;
      r = drdata_i;
      dreq_o = 1'h0;
      daddr_o = ~daddr_o;
   endtask
endmodule
`default_nettype wire

/* verif/tb.sv */
`default_nettype none
module tb
   import activity_counter_enable_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic [DATA_W-1:0] trap_mask = 32'h1 << TRAP_BIT_POS;
   logic [DATA_W-1:0] l3_ctl = 32'hBFFFFFFF;
   logic [DATA_W-1:0] l2_ctl = 32'hBFFFFFFF;
   logic req, wr, ns, dreq, dwr, ack_w, trap_w, dack_w, derr_w;
   logic [1:0] op0, el, tel_w;
   logic [2:0] op1, op2;
   logic [3:0] crn, crm;
   logic [DATA_W-1:0] wdata, rdata_w, drdata_w;
   logic [DBG_ADDR_W-1:0] daddr;
   logic [3:0] en_arch, arch_m;
   logic [2:0] en_aux, aux_m;
   logic ack, tr, dack, derr, t3, t2, tns;
   logic [1:0] tel, tlev, etel;
   logic [DATA_W-1:0] rd, drd;
   logic [3:0] vcrm [4] = '{SR_CRM_ARCH, SR_CRM_ARCH, SR_CRM_AUX, SR_CRM_AUX};
   logic [2:0] vop2 [4] = '{SR_OP2_ARCH_CLR, SR_OP2_ARCH_SET, SR_OP2_AUX_CLR, SR_OP2_AUX_SET};
   logic [11:0] vofs [4] = '{DBG_ARCH_CLR_OFS, DBG_ARCH_SET_OFS, DBG_AUX_CLR_OFS,
      DBG_AUX_SET_OFS};
   // Trap cases: level-3 bit, level-2 bit, level, non-secure, expected target
   logic [6:0] tcase [9] = '{7'h53, 7'h47, 7'h58, 7'h2E, 7'h26, 7'h28, 7'h34, 7'h6F, 7'h7C};
   int err_count = 0;
   int tests_run = 0;
   always #50 clk = ~clk;
   core_access_model bfm (.clk_i(clk), .req_o(req), .wr_o(wr), .op0_o(op0), .op1_o(op1),
      .crn_o(crn), .crm_o(crm), .op2_o(op2), .wdata_o(wdata), .el_o(el), .ns_o(ns),
      .dreq_o(dreq), .dwr_o(dwr), .daddr_o(daddr), .ack_i(ack_w), .rdata_i(rdata_w),
      .trap_i(trap_w), .trap_el_i(tel_w), .dack_i(dack_w), .derr_i(derr_w),
      .drdata_i(drdata_w));
   activity_counter_enable_regs dut (.sys_clk_i(clk), .rst_i(rst), .sysreg_req_i(req),
      .sysreg_write_i(wr), .sysreg_op0_i(op0), .sysreg_op1_i(op1), .sysreg_crn_i(crn),
      .sysreg_crm_i(crm), .sysreg_op2_i(op2), .sysreg_wdata_i(wdata), .sysreg_el_i(el),
      .sysreg_nonsecure_i(ns), .level3_aux_control_i(l3_ctl),
      .level2_aux_control_i(l2_ctl), .sysreg_ack_o(ack_w), .sysreg_rdata_o(rdata_w),
      .sysreg_trap_o(trap_w), .sysreg_trap_el_o(tel_w), .dbg_req_i(dreq), .dbg_write_i(dwr),
      .dbg_addr_i(daddr), .dbg_ack_o(dack_w), .dbg_err_o(derr_w), .dbg_rdata_o(drdata_w),
      .arch_count_enable_o(en_arch), .aux_count_enable_o(en_aux));
   task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("tests_run=%0d err_count=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Reads every view on both ports and the enable outputs
   task automatic read_all();
      logic [DATA_W-1:0] e;
      for (int v = 0; v < 4; v++) begin
         e = (v < 2) ? {28'h0, arch_m} : {29'h0, aux_m};
         bfm.sr(1'h0, vcrm[v], vop2[v], 32'hFFFFFFFF, EL0, 1'h0, ack, rd, tr, tel);
         check(ack, 1'h1);
         check(rd, e);
         bfm.dr(1'h0, vofs[v], dack, derr, drd);
         check({dack, derr}, 2'h2);
         check(drd, e);
      end
      check(en_arch, arch_m);
      check(en_aux, aux_m);
   endtask
   task automatic wr_view(input int v, input logic [DATA_W-1:0] d);
      bfm.sr(1'h1, vcrm[v], vop2[v], d, EL0, 1'h0, ack, rd, tr, tel);
      case (v)
         0: arch_m = arch_m & ~d[3:0];
         1: arch_m = arch_m | d[3:0];
         2: aux_m = aux_m & ~d[2:0];
         default: aux_m = aux_m | d[2:0];
      endcase
      check(ack, 1'h1);
      check(rd, 32'h0);
      check({tr, tel}, 3'h0);
      check(en_arch, arch_m);
      check(en_aux, aux_m);
   endtask
   // Other bits of the control words are set whenever the trap bit is clear
   task automatic set_ctl(input logic a3, input logic a2);
      l3_ctl = a3 ? trap_mask : ~trap_mask;
      l2_ctl = a2 ? trap_mask : ~trap_mask;
   endtask
   initial begin
      #200us;
      err_count++;
      end_of_test();
   end
   initial begin
      arch_m = 4'h0;
      aux_m = 3'h0;
      repeat (4) @(negedge clk);
      rst = 1'h0;
      read_all();
      wr_view(1, 32'hFFFFFFF5);
      wr_view(1, 32'h00000000);
      wr_view(0, 32'hFFFFFFF4);
      wr_view(3, 32'hFFFFFFFE);
      wr_view(2, 32'hFFFFFFFC);
      read_all();
      bfm.dr(1'h1, DBG_ARCH_SET_OFS, dack, derr, drd);
      check({dack, derr}, 2'h3);
      check(drd, 32'h0);
      bfm.dr(1'h0, 12'hC08, dack, derr, drd);
      check({dack, derr}, 2'h3);
      check(drd, 32'h0);
      bfm.sr(1'h1, SR_CRM_ARCH, 3'h6, 32'hF, EL0, 1'h0, ack, rd, tr, tel);
      check(ack, 1'h0);
      bfm.sr(1'h1, SR_CRM_AUX, 3'h2, 32'h7, EL0, 1'h0, ack, rd, tr, tel);
      check(ack, 1'h0);
      read_all();
      for (int i = 0; i < 9; i++) begin
         {t3, t2, tlev, tns, etel} = tcase[i];
         set_ctl(1'h0, 1'h0);
         wr_view(1, 32'hF);
         set_ctl(t3, t2);
         bfm.sr(1'h1, SR_CRM_ARCH, SR_OP2_ARCH_CLR, 32'hF, tlev, tns, ack, rd, tr, tel);
         if (etel == 2'h0) begin
            arch_m = 4'h0;
         end
         check({ack, tr, tel}, {1'h1, etel != 2'h0, etel});
         check(rd, 32'h0);
         check(en_arch, arch_m);
      end
      set_ctl(1'h0, 1'h0);
      // Back-to-back set write and clear read see one shared flop
      bfm.sr_pair(32'hFFFFFFF6, ack, rd);
      arch_m = arch_m | 4'h6;
      check(ack, 1'h1);
      check(rd, {28'h0, arch_m});
      check(en_arch, arch_m);
      // Reset in mid-run drops every enable
      rst = 1'h1;
      repeat (2) @(negedge clk);
      rst = 1'h0;
      arch_m = 4'h0;
      aux_m = 3'h0;
      read_all();
      end_of_test();
   end
endmodule
`default_nettype wire
